/* File: hdl/fss_status.sv */
// fault summary status word with its serial frame engine
`timescale 1ns/1ns
module fss_status (
    input wire logic i_clk, // 25 MHz device clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_sclk, // serial clock pin
    input wire logic i_cs_n, // chip select pin, active low
    input wire logic i_sdi, // serial data in pin
    input wire fss_pkg::fss_groups_t i_groups, // unmasked group faults
    output logic o_sdo, // serial data out
    output logic o_sdo_oe_n // sdo output enable, active low
);
    import fss_pkg::*;

    localparam logic [11:0] TO_LAST = 12'(TIMEOUT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    fss_pins_t pins_raw;
    fss_pins_t pins;

    assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, sdi: i_sdi};

    fss_sync2 u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    fss_state_t state, next_state;
    logic sclk_d, next_sclk_d;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [39:0] rx_sh, next_rx_sh;
    logic [39:0] tx_sh, next_tx_sh;
    logic [11:0] to_cnt, next_to_cnt;
    logic to_hit, next_to_hit;
    logic next_sdo, next_sdo_oe_n;
    logic restart_n, next_restart_n;
    logic [3:0] alarm_n, next_alarm_n;
    logic crc_n, next_crc_n;
    logic to_n, next_to_n;
    logic cnt_n, next_cnt_n;
    logic addr_n, next_addr_n;
    logic [3:0] resp, next_resp;
    logic rd_pend, next_rd_pend;
    logic rd_hit, next_rd_hit;

    // decoded frame contents and events
    logic sclk_rise, sclk_fall, end_frame;
    logic cnt_ok, crc_ok, good, addr_bad, wr_ok;
    logic [1:0] op;
    logic [8:0] addr;
    logic [15:0] wdata, status_word, rd_word;
    logic [3:0] grp_act, grp_clr;

    // assembled status word, low three bits read zero
    assign status_word = {restart_n, alarm_n, crc_n, to_n, cnt_n, addr_n,
                          resp, 3'b000};
    assign rd_word = rd_hit ? status_word : 16'h0000;

    assign sclk_rise = pins.sclk & ~sclk_d;
    assign sclk_fall = ~pins.sclk & sclk_d;
    assign end_frame = (state != ST_IDLE) & pins.cs_n;

    // frame decode, valid at end of frame
    assign op = rx_sh[39:38];
    assign addr = rx_sh[32:24];
    assign wdata = rx_sh[23:8];
    assign cnt_ok = (bit_cnt == FRAME_BITS);
    assign crc_ok = (fss_crc8(rx_sh[39:8]) == rx_sh[7:0]);
    assign good = cnt_ok & crc_ok & ~to_hit;
    assign addr_bad = (op == OP_READ || op == OP_WRITE) && addr >= ADDR_LIMIT;
    assign wr_ok = end_frame & good & (op == OP_WRITE) &
                   (addr == ADDR_STATUS);

    assign grp_act = {i_groups.power, i_groups.timing,
                      i_groups.logic_grp, i_groups.overcurrent};
    // only bits 14..11 clear the alarm flags, only on a one in the data
    assign grp_clr = wr_ok ? wdata[BIT_POWER:BIT_OVERCUR] : 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // frame engine and status flags, next values
    always_comb begin
        next_state = state;
        next_sclk_d = pins.sclk;
        next_bit_cnt = bit_cnt;
        next_rx_sh = rx_sh;
        next_tx_sh = tx_sh;
        next_to_cnt = to_cnt;
        next_to_hit = to_hit;
        next_sdo = o_sdo;
        next_sdo_oe_n = o_sdo_oe_n;
        next_crc_n = crc_n;
        next_to_n = to_n;
        next_cnt_n = cnt_n;
        next_addr_n = addr_n;
        next_resp = resp;
        next_rd_pend = rd_pend;
        next_rd_hit = rd_hit;
        case (state)
            ST_IDLE: begin
                if (!pins.cs_n) begin
                    next_state = ST_SHIFT;
                    next_bit_cnt = 6'h00;
                    next_to_cnt = 12'h000;
                    next_to_hit = 1'b0;
                    next_tx_sh = {status_word, rd_word,
                                  fss_crc8({status_word, rd_word})};
                    next_sdo = status_word[15];
                    next_sdo_oe_n = 1'b0;
                end
            end
            ST_SHIFT: begin
                next_to_cnt = to_cnt + 12'h001;
                if (to_cnt == TO_LAST) begin
                    // frame too long: stop driving, wait for deselect
                    next_state = ST_WAIT;
                    next_to_hit = 1'b1;
                    next_sdo_oe_n = 1'b1;
                end
                if (sclk_rise) begin
                    next_rx_sh = {rx_sh[38:0], pins.sdi};
                    if (bit_cnt != 6'h3F) begin
                        next_bit_cnt = bit_cnt + 6'h01;
                    end
                end
                if (sclk_fall) begin
                    next_tx_sh = {tx_sh[38:0], 1'b0};
                    next_sdo = tx_sh[38];
                end
            end
            default: begin
            end
        endcase
        // per-frame flags renewed only at frame end
        if (end_frame) begin
            next_state = ST_IDLE;
            next_sdo_oe_n = 1'b1;
            next_sdo = 1'b0;
            next_crc_n = ~(cnt_ok & ~crc_ok & ~to_hit);
            next_to_n = ~to_hit;
            next_cnt_n = cnt_ok | to_hit;
            next_addr_n = ~(good & addr_bad);
            next_rd_pend = good & (op == OP_READ) & ~addr_bad;
            next_rd_hit = good & (op == OP_READ) & (addr == ADDR_STATUS);
            // response code for the frame just ended
            if (!good) begin
                next_resp = RESP_ERR;
            end else if (op == OP_NULL) begin
                next_resp = rd_pend ? RESP_NULL_RD2 : RESP_NULL;
            end else if (op == OP_READ) begin
                next_resp = RESP_READ;
            end else if (op == OP_WRITE) begin
                next_resp = RESP_WRITE;
            end else begin
                next_resp = RESP_BADCMD;
            end
        end
    end

    // sticky flags: a present fault wins over a write of one
    always_comb begin
        next_restart_n = restart_n;
        if (wr_ok && wdata[BIT_RESTART]) begin
            next_restart_n = 1'b1;
        end
        for (int g = 0; g < 4; g++) begin
            if (grp_act[g]) begin
                next_alarm_n[g] = 1'b0;
            end else if (grp_clr[g]) begin
                next_alarm_n[g] = 1'b1;
            end else begin
                next_alarm_n[g] = alarm_n[g];
            end
        end
    end

    // registers, reset to the documented word
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            sclk_d <= 1'b0;
            bit_cnt <= 6'h00;
            rx_sh <= 40'h00_0000_0000;
            tx_sh <= 40'h00_0000_0000;
            to_cnt <= 12'h000;
            to_hit <= 1'b0;
            o_sdo <= 1'b0;
            o_sdo_oe_n <= 1'b1;
            restart_n <= STATUS_RESET[BIT_RESTART];
            alarm_n <= STATUS_RESET[BIT_POWER:BIT_OVERCUR];
            crc_n <= STATUS_RESET[10];
            to_n <= STATUS_RESET[9];
            cnt_n <= STATUS_RESET[8];
            addr_n <= STATUS_RESET[7];
            resp <= STATUS_RESET[RESP_LSB+3:RESP_LSB];
            rd_pend <= 1'b0;
            rd_hit <= 1'b0;
        end else begin
            state <= next_state;
            sclk_d <= next_sclk_d;
            bit_cnt <= next_bit_cnt;
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            to_cnt <= next_to_cnt;
            to_hit <= next_to_hit;
            o_sdo <= next_sdo;
            o_sdo_oe_n <= next_sdo_oe_n;
            restart_n <= next_restart_n;
            alarm_n <= next_alarm_n;
            crc_n <= next_crc_n;
            to_n <= next_to_n;
            cnt_n <= next_cnt_n;
            addr_n <= next_addr_n;
            resp <= next_resp;
            rd_pend <= next_rd_pend;
            rd_hit <= next_rd_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_restart_low: assert property ($fell(i_sys_rst) |-> !restart_n)
        else $error("restart flag not low after reset");
    a_restart_rise: assert property ($rose(restart_n) |->
        $past(wr_ok && wdata[BIT_RESTART]))
        else $error("restart flag rose without a write of one");
    a_power_follow: assert property (i_groups.power |=> !alarm_n[3])
        else $error("power alarm not set by a power fault");
    a_power_sticky: assert property ($rose(alarm_n[3]) |->
        $past(!i_groups.power && grp_clr[3]))
        else $error("power alarm cleared while fault present or unwritten");
    a_timing_follow: assert property (i_groups.timing |=> !alarm_n[2])
        else $error("timing alarm not set");
    a_logic_follow: assert property (i_groups.logic_grp |=> !alarm_n[1])
        else $error("logic alarm not set");
    a_ocur_follow: assert property (i_groups.overcurrent |=> !alarm_n[0])
        else $error("overcurrent alarm not set");
    a_crc_flag: assert property (end_frame |=>
        crc_n == !($past(cnt_ok && !crc_ok && !to_hit)))
        else $error("checksum flag wrong after frame");
    a_timeout_hit: assert property (state == ST_SHIFT && to_cnt == TO_LAST
        && !pins.cs_n |=> state == ST_WAIT && o_sdo_oe_n)
        else $error("timeout did not end the frame");
    a_timeout_flag: assert property (end_frame |=> to_n == !$past(to_hit))
        else $error("timeout flag wrong after frame");
    a_count_flag: assert property (end_frame && !to_hit |=>
        cnt_n == $past(bit_cnt == FRAME_BITS))
        else $error("edge count flag wrong after frame");
    a_addr_flag: assert property (end_frame && good && addr_bad |=>
        !addr_n ##1 !addr_n)
        else $error("bad address flag not set");
    a_addr_hold: assert property (state != ST_IDLE && !end_frame |=>
        $stable(addr_n) && $stable(crc_n))
        else $error("frame flags changed inside a frame");
    a_reset_word: assert property ($fell(i_sys_rst) |->
        status_word == STATUS_RESET)
        else $error("status word reset value wrong");
    a_resp_err: assert property (end_frame && !good |=>
        resp == RESP_ERR)
        else $error("error frame not reported");
    a_zero_write: assert property (wr_ok && !wdata[BIT_RESTART] |=>
        restart_n == $past(restart_n))
        else $error("writing zero changed the restart flag");

    c_read_frame: cover property (end_frame && good && op == OP_READ);
    c_write_clear: cover property (wr_ok ##1 restart_n);
    c_timeout: cover property (state == ST_WAIT ##[1:50] end_frame);
    c_bad_addr: cover property ($fell(addr_n));
endmodule

/* File: hdl/fss_pkg.sv */
// fault summary status word: shared constants, types and checksum
package fss_pkg;

    // register map
    localparam logic [8:0] ADDR_STATUS = 9'h001;
    localparam logic [8:0] ADDR_LIMIT = 9'h0FF;
    localparam logic [15:0] STATUS_RESET = 16'h7FC8;

    // field positions inside the status word
    localparam int BIT_RESTART = 15;
    localparam int BIT_POWER = 14;
    localparam int BIT_TIMING = 13;
    localparam int BIT_LOGIC = 12;
    localparam int BIT_OVERCUR = 11;
    localparam int RESP_LSB = 3;

    // command response codes
    localparam logic [3:0] RESP_NULL = 4'h1;
    localparam logic [3:0] RESP_READ = 4'h4;
    localparam logic [3:0] RESP_NULL_RD2 = 4'h5;
    localparam logic [3:0] RESP_WRITE = 4'h6;
    localparam logic [3:0] RESP_RESET = 4'h9;
    localparam logic [3:0] RESP_ERR = 4'hA;
    localparam logic [3:0] RESP_BADCMD = 4'hB;

    // frame layout: command 16, data 16, checksum 8
    localparam logic [1:0] OP_NULL = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [5:0] FRAME_BITS = 6'h28;

    // frame timeout
    localparam int CLK_MHZ = 25;
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

    // unmasked fault group summaries, active high
    typedef struct packed {
        logic power;
        logic timing;
        logic logic_grp;
        logic overcurrent;
    } fss_groups_t;

    // serial pins as one bundle
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } fss_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_WAIT = 2'b11
    } fss_state_t;

    // crc-8, polynomial 07h, seed 00h, msb first
    function automatic logic [7:0] fss_crc8(input logic [31:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction

endpackage

/* File: hdl/fss_sync2.sv */
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ns
module fss_sync2 (
    input wire logic i_clk, // device clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire fss_pkg::fss_pins_t i_async, // raw pins
    output fss_pkg::fss_pins_t o_sync // pins in clock domain
);
    import fss_pkg::*;

    fss_pins_t meta;
    fss_pins_t next_meta;
    fss_pins_t next_sync;

    // idle pin levels: clock low, chip select high
    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
            o_sync <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule

/* File: bench/fss_host.sv */
// host-side serial master model for the status word link
`timescale 1ns/1ns
module fss_host (
    input wire logic i_clk, // device clock, paces the bit phases
    input wire logic i_sdo, // device serial out
    input wire logic i_sdo_oe_n, // device sdo enable, active low
    output fss_pkg::fss_pins_t o_pins // sclk, cs_n and sdi to the device
);
    import fss_pkg::*;
    logic last_sdo = 1'b0;
    logic sdo_line;

    ////////////////////////////////////////////////////////////////////
    // a released sdo line shows the inverse of its last driven level
    always @(posedge i_clk) begin
        if (!i_sdo_oe_n) begin
            last_sdo <= i_sdo;
        end
    end
    assign sdo_line = i_sdo_oe_n ? ~last_sdo : i_sdo;

    // idle pins: deselected, sclk low
    initial begin
        o_pins = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
    end

    ////////////////////////////////////////////////////////////////////
    // one frame: sclk idles low, 4 clocks per phase, msb first
    task automatic xfer(input logic [39:0] tx, input int nbits,
                        input int hold, output logic [39:0] rx);
        rx = '0;
        @(posedge i_clk) #1;
        o_pins.cs_n = 1'b0;
        o_pins.sdi = tx[39];
        repeat (8) @(posedge i_clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (4) @(posedge i_clk);
            #1 o_pins.sclk = 1'b1;
            repeat (4) @(posedge i_clk);
            #1 if (i < 40) begin
                rx[39 - i] = sdo_line; // read late in the high phase
            end
            o_pins.sclk = 1'b0;
            o_pins.sdi = (i < 39) ? tx[38 - i] : 1'b0; // sdi moves on fall
        end
        // hold stretches the frame past the device timeout
        repeat (4 + hold) @(posedge i_clk);
        #1 o_pins.cs_n = 1'b1;
        o_pins.sdi = 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

/* File: bench/fss_status_tb.sv */
// self-checking bench for the fault summary status word
`timescale 1ns/1ns
module fss_status_tb;
    import fss_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fss_pins_t pins;
    fss_groups_t grp = '0;
    logic sdo;
    logic oe_n;
    int fails = 0;
    int n_checks = 0;
    logic rd_prev = 1'b0; // last frame was a good read of a valid address
    logic [15:0] exp_word; // status word expected in the last frame
    logic [31:0] lfsr = 32'hcea7_eda5;
    logic [31:0] r;
    logic [4:0] sticky = 5'h0f; // expected bits 15..11
    logic [3:0] prev_err = 4'hf; // expected bits 10..7
    logic [3:0] prev_resp = RESP_RESET;
    logic [15:0] rdata;

    always #20 clk = ~clk;

    fss_status DUT (.i_clk(clk), .i_sys_rst(rst), .i_sclk(pins.sclk),
        .i_cs_n(pins.cs_n), .i_sdi(pins.sdi), .i_groups(grp),
        .o_sdo(sdo), .o_sdo_oe_n(oe_n));
    fss_host host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe_n(oe_n),
        .o_pins(pins));

    ////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] next_rand();
        for (int i = 0; i < 32; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        end
        return lfsr;
    endfunction

    function automatic logic [7:0] crc_of(input logic [31:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input logic [15:0] mask);
        n_checks++;
        if ((got & mask) !== (exp & mask)) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // one frame: check the status shifted out, then predict its effect
    task automatic frame(input logic [1:0] op, input logic [8:0] addr,
                         input logic [15:0] data, input int nbits,
                         input int hold, input logic badcrc);
        logic [31:0] word;
        logic [39:0] rx;
        logic [15:0] mask;
        logic rd_was;
        word = {op, 5'h00, addr, data};
        sticky = sticky & ~{1'b0, grp};
        mask = (nbits >= 16) ? 16'hffff : 16'hff00;
        host.xfer({word, crc_of(word) ^ {7'h00, badcrc}}, nbits, hold, rx);
        exp_word = {sticky, prev_err, prev_resp, 3'h0};
        check(rx[39:24], exp_word, mask);
        rdata = rx[23:8];
        rd_was = rd_prev;
        rd_prev = 1'b0;
        if (hold > 0) begin
            prev_err = 4'b1011;
            prev_resp = RESP_ERR;
        end else if (nbits != 40) begin
            prev_err = 4'b1101;
            prev_resp = RESP_ERR;
        end else if (badcrc) begin
            prev_err = 4'b0111;
            prev_resp = RESP_ERR;
        end else begin
            prev_err = 4'hf;
            rd_prev = (op == OP_READ) && (addr < ADDR_LIMIT);
            if (op inside {OP_READ, OP_WRITE} && addr >= ADDR_LIMIT) begin
                prev_err[0] = 1'b0;
            end
            case (op)
                OP_NULL: prev_resp = rd_was ? RESP_NULL_RD2 : RESP_NULL;
                OP_READ: prev_resp = RESP_READ;
                OP_WRITE: prev_resp = RESP_WRITE;
                default: prev_resp = RESP_BADCMD;
            endcase
            if (op == OP_WRITE && addr == ADDR_STATUS) begin
                sticky = sticky | (data[15:11] & ~{1'b0, grp});
            end
        end
    endtask

    task automatic nul();
        frame(OP_NULL, 9'h000, 16'h0000, 40, 0, 1'b0);
    endtask

    task automatic wr(input logic [15:0] data);
        frame(OP_WRITE, ADDR_STATUS, data, 40, 0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        nul();
        wr(16'h0000);
        wr(16'h07ff);
        wr(16'h8000);
        for (int g = 0; g < 4; g++) begin
            @(posedge clk) #1 grp = 4'h8 >> g;
            nul();
            wr(16'hf800);
            @(posedge clk) #1 grp = '0;
            wr(16'h0000);
            wr(16'h8000 >> (g + 1));
        end
        frame(OP_NULL, 9'h000, 16'h0000, 40, 0, 1'b1);
        frame(OP_WRITE, ADDR_STATUS, 16'h8000, 39, 0, 1'b0);
        frame(OP_READ, ADDR_STATUS, 16'h0000, 41, 0, 1'b0);
        frame(OP_NULL, 9'h000, 16'h0000, 8, 2600, 1'b0);
        frame(OP_WRITE, ADDR_LIMIT, 16'hffff, 40, 0, 1'b0);
        frame(OP_READ, 9'h1ff, 16'h0000, 40, 0, 1'b0);
        nul();
        frame(OP_READ, 9'h002, 16'h0000, 40, 0, 1'b0);
        nul();
        check(rdata, 16'h0000, 16'hffff);
        // read back the status word itself through the two-frame read
        frame(OP_READ, ADDR_STATUS, 16'h0000, 40, 0, 1'b0);
        nul();
        check(rdata, exp_word, 16'hffff);
        frame(2'h3, ADDR_STATUS, 16'h0000, 40, 0, 1'b0);
        nul();
        // random group faults and writes
        for (int k = 0; k < 24; k++) begin
            r = next_rand();
            @(posedge clk) #1 grp = r[3:0] & {4{r[4]}};
            frame(r[5] ? OP_WRITE : OP_NULL, r[6] ? ADDR_STATUS : 9'h002,
                r[31:16], 40, 0, 1'b0);
        end
        @(posedge clk) #1 grp = '0;
        nul();
        finish_test();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
